// [ref_map.svh]
// Constants of the relative reference unit: widths, codes and range limits
`ifndef REF_MAP_SVH
`define REF_MAP_SVH

// Data format: signed fixed point, 48 bits with 16 fraction bits
`define VAL_W        48
`define FRAC_W       16
`define FUNC_W       4
`define FUNC_COUNT   9
`define FUNC_IDX_W   4
// Bit of an answer that carries an enable flag
`define FLAG_BIT     0

// Reset default reference for every function
`define REF_DEFAULT  48'sh0000_0000_0000

// Range limits, value times 2**16
`define LIM_CUR_HI     48'sh0000_0003_199A
`define LIM_AC_VOLT_HI 48'sh0000_02F5_8000
`define LIM_DC_VOLT_HI 48'sh0000_03F2_0000
`define LIM_RES_HI     48'sh0727_0E00_0000
`define LIM_FRQ_HI     48'sh00E4_E1C0_0000
`define LIM_PERIOD_HI  48'sh0000_0001_0000
`define LIM_TMP_HI     48'sh0000_055C_0000
`define LIM_TMP_MAG    48'sh0000_00C8_0000
`define LIM_ZERO       48'sh0000_0000_0000

`endif

// [ref_pkg.sv]
// Types of the relative reference unit
`include "ref_map.svh"
package ref_pkg;

  typedef enum logic [`FUNC_W-1:0] {
    ac_current_function,
    dc_current_function,
    ac_voltage_function,
    dc_voltage_function,
    res2_function,
    res4_function,
    frequency_function,
    period_function,
    temperature_function
  } func_t;

  typedef enum logic [2:0] {
    OP_SET_REF,
    OP_SET_STATE,
    OP_ACQUIRE,
    OP_QUERY_REF,
    OP_QUERY_STATE
  } op_t;

  typedef enum logic [1:0] {
    PSEL_VALUE,
    PSEL_DEFAULT,
    PSEL_MIN,
    PSEL_MAX
  } psel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RESP = 2'b11
  } state_t;

  typedef struct packed {
    op_t                     op;
    func_t                   func;
    psel_t                   psel;
    logic                    on;
    logic signed [`VAL_W-1:0] value;
  } cmd_t;

  typedef struct packed {
    logic signed [`VAL_W-1:0] data;
    logic                    src_acquired;
    logic                    param_error;
    logic                    acquire_error;
  } resp_t;

  typedef struct packed {
    logic signed [`VAL_W-1:0] value;
    logic                    overflow;
  } reading_t;

endpackage : ref_pkg

// [ref_limits.sv]
// Lowest and highest allowed reference value of each measurement function
`timescale 1ns/1ns
`include "ref_map.svh"
module ref_limits
  import ref_pkg::*;
(
  // Addressed function
  input  func_t                    func,
  // Range limits
  output logic signed [`VAL_W-1:0] lo,
  output logic signed [`VAL_W-1:0] hi
);

  always_comb begin
    lo = `LIM_ZERO;
    hi = `LIM_ZERO;
    case (func)
      ac_current_function, dc_current_function: begin
        lo = -`LIM_CUR_HI;
        hi = `LIM_CUR_HI;
      end
      ac_voltage_function: begin
        lo = -`LIM_AC_VOLT_HI;
        hi = `LIM_AC_VOLT_HI;
      end
      dc_voltage_function: begin
        lo = -`LIM_DC_VOLT_HI;
        hi = `LIM_DC_VOLT_HI;
      end
      res2_function, res4_function: begin
        hi = `LIM_RES_HI;
      end
      frequency_function: begin
        hi = `LIM_FRQ_HI;
      end
      period_function: begin
        hi = `LIM_PERIOD_HI;
      end
      temperature_function: begin
        lo = -`LIM_TMP_MAG;
        hi = `LIM_TMP_HI;
      end
      default: begin
        lo = `LIM_ZERO;
        hi = `LIM_ZERO;
      end
    endcase
  end

endmodule : ref_limits

// [relative_reference_offset.sv]
// Per-function relative reference: programming, acquiring, queries and offset of readings
// Operation
// - Programmed references are accepted only within each function's range (volts, ohms).
// - Every reference resets to zero and the default query returns zero.
// - MIN and MAX parameters select and report the addressed function's range limits.
// - With the reference enabled, each result is the reading minus that function's reference.
// - Each function has its own reference and only the addressed one is updated.
// - Programming and acquiring write the same reference and the later one wins.
// - The reference query returns the programmed number or the captured reading, whichever was last.
// - A per-function enable flag is set by 1/ON, cleared by 0/OFF and can be queried.
// - With the flag clear readings pass unchanged and the stored reference is kept.
// - Acquiring on the active function stores the latest reading as its reference.
// - Acquiring for another function raises an error and changes nothing.
// - Acquiring after an overflow or before any reading raises an error instead.
// - Current functions accept programmed references only from -3.1 to 3.1.
`timescale 1ns/1ns
`include "ref_map.svh"
module relative_reference_offset
  import ref_pkg::*;
(
  // Clock and reset
  input  logic                    clock,
  input  logic                    resetn,
  // Command side
  input  logic                    cmd_valid,
  output logic                    cmd_ready,
  input  cmd_t                    cmd,
  output logic                    resp_valid,
  output resp_t                   resp,
  // Measurement side
  input  func_t                   active_function,
  input  logic                    reading_valid,
  input  reading_t                reading,
  output logic                    result_valid,
  output reading_t                result,
  // Status
  output logic [`FUNC_COUNT-1:0]  relative_mode
);

  state_t                   state_r;
  state_t                   state_nxt;
  cmd_t                     cmd_r;
  resp_t                    resp_r;
  resp_t                    resp_nxt;
  reading_t                 result_r;
  logic                     result_valid_r;

  logic signed [`VAL_W-1:0] ref_value_r [`FUNC_COUNT];
  logic [`FUNC_COUNT-1:0]   ref_acq_r;
  logic [`FUNC_COUNT-1:0]   ref_on_r;

  logic signed [`VAL_W-1:0] last_value_r;
  logic                     last_ovf_r;
  logic                     have_reading_r;
  func_t                    last_func_r;

  logic signed [`VAL_W-1:0] lim_lo;
  logic signed [`VAL_W-1:0] lim_hi;
  logic signed [`VAL_W-1:0] sel_val;
  logic signed [`VAL_W-1:0] cur_ref;
  logic signed [`VAL_W-1:0] act_ref;
  logic signed [`VAL_W-1:0] act_offset;
  logic [`FUNC_IDX_W-1:0]   cmd_idx;
  logic [`FUNC_IDX_W-1:0]   act_idx;
  logic                     exec;
  logic                     func_ok;
  logic                     act_ok;
  logic                     in_range;
  logic                     is_set;
  logic                     is_state;
  logic                     is_acq;
  logic                     set_ok;
  logic                     cur_acq;
  logic                     acq_func_err;
  logic                     acq_read_err;
  logic                     acq_ok;
  logic                     ref_we;
  logic                     func_changed;

  function automatic logic idx_ok(input func_t f);
    idx_ok = (f <= temperature_function);
  endfunction : idx_ok

  // Range limits of the addressed function
  ref_limits u_limits (
    .func (cmd_r.func),
    .lo   (lim_lo),
    .hi   (lim_hi)
  );

  // Command decode
  assign exec         = (state_r == ST_EXEC);
  assign cmd_idx      = cmd_r.func;
  assign act_idx      = active_function;
  assign func_ok      = idx_ok(cmd_r.func);
  assign act_ok       = idx_ok(active_function);
  assign is_set       = exec && (cmd_r.op == OP_SET_REF);
  assign is_state     = exec && (cmd_r.op == OP_SET_STATE);
  assign is_acq       = exec && (cmd_r.op == OP_ACQUIRE);

  // Parameter selection and range check
  assign sel_val      = (cmd_r.psel == PSEL_DEFAULT) ? `REF_DEFAULT :
                        (cmd_r.psel == PSEL_MIN)     ? lim_lo :
                        (cmd_r.psel == PSEL_MAX)     ? lim_hi :
                                                       cmd_r.value;
  assign in_range     = (sel_val >= lim_lo) && (sel_val <= lim_hi);
  assign set_ok       = is_set && func_ok && in_range;
  assign cur_acq      = func_ok && ref_acq_r[cmd_idx];
  assign cur_ref      = func_ok ? ref_value_r[cmd_idx] : `REF_DEFAULT;

  // Acquire checks
  assign acq_func_err = !func_ok || (cmd_r.func != active_function);
  assign acq_read_err = !have_reading_r || last_ovf_r;
  assign acq_ok       = is_acq && !acq_func_err && !acq_read_err;
  assign ref_we       = set_ok || acq_ok;

  // Offset applied to readings
  assign act_ref      = act_ok ? ref_value_r[act_idx] : `REF_DEFAULT;
  assign act_offset   = (act_ok && ref_on_r[act_idx]) ? act_ref : `REF_DEFAULT;
  assign func_changed = (active_function != last_func_r);

  // Answer built in the execute cycle
  always_comb begin
    resp_nxt               = resp_r;
    resp_nxt.param_error   = 1'b0;
    resp_nxt.acquire_error = 1'b0;
    resp_nxt.src_acquired  = cur_acq;
    case (cmd_r.op)
      OP_SET_REF: begin
        resp_nxt.data        = set_ok ? sel_val : cur_ref;
        resp_nxt.param_error = !func_ok || !in_range;
        resp_nxt.src_acquired = set_ok ? 1'b0 : cur_acq;
      end
      OP_SET_STATE: begin
        resp_nxt.data        = `LIM_ZERO;
        resp_nxt.data[`FLAG_BIT] = cmd_r.on;
        resp_nxt.param_error = !func_ok;
      end
      OP_ACQUIRE: begin
        resp_nxt.data          = acq_ok ? last_value_r : cur_ref;
        resp_nxt.acquire_error = !acq_ok;
        resp_nxt.src_acquired  = acq_ok || cur_acq;
      end
      OP_QUERY_REF: begin
        resp_nxt.data        = (cmd_r.psel == PSEL_VALUE) ? cur_ref : sel_val;
        resp_nxt.param_error = !func_ok;
      end
      OP_QUERY_STATE: begin
        resp_nxt.data        = `LIM_ZERO;
        resp_nxt.data[`FLAG_BIT] = func_ok && ref_on_r[cmd_idx];
        resp_nxt.param_error = !func_ok;
      end
      default: begin
        resp_nxt.data        = `LIM_ZERO;
        resp_nxt.param_error = 1'b1;
      end
    endcase
  end

  // Command sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cmd_valid) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_nxt = ST_RESP;
      end
      ST_RESP: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  assign cmd_ready     = (state_r == ST_IDLE);
  assign resp_valid    = (state_r == ST_RESP);
  assign resp          = resp_r;
  assign result        = result_r;
  assign result_valid  = result_valid_r;
  assign relative_mode = ref_on_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      cmd_r   <= '0;
      resp_r  <= '0;
    end else begin
      state_r <= state_nxt;
      if (cmd_valid && cmd_ready) begin
        cmd_r <= cmd;
      end
      if (exec) begin
        resp_r <= resp_nxt;
      end
    end
  end

  // Per-function reference store
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `FUNC_COUNT; i++) begin
        ref_value_r[i] <= `REF_DEFAULT;
      end
      ref_acq_r <= '0;
      ref_on_r  <= '0;
    end else begin
      if (ref_we) begin
        ref_value_r[cmd_idx] <= acq_ok ? last_value_r : sel_val;
        ref_acq_r[cmd_idx]   <= acq_ok;
      end
      if (is_state && func_ok) begin
        ref_on_r[cmd_idx] <= cmd_r.on;
      end
    end
  end

  // Latest reading of the active function
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      last_value_r   <= `REF_DEFAULT;
      last_ovf_r     <= 1'b0;
      have_reading_r <= 1'b0;
      last_func_r    <= ac_current_function;
    end else begin
      last_func_r <= active_function;
      if (reading_valid) begin
        last_value_r   <= reading.value;
        last_ovf_r     <= reading.overflow;
        have_reading_r <= 1'b1;
      end else if (func_changed) begin
        have_reading_r <= 1'b0;
      end
    end
  end

  // Result path
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_r       <= '0;
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= reading_valid;
      if (reading_valid) begin
        result_r.value    <= reading.value - act_offset;
        result_r.overflow <= reading.overflow;
      end
    end
  end

endmodule : relative_reference_offset

// [ref_host.sv]
// Host model that issues commands and collects the answers
`timescale 1ns/1ns
module ref_host
  import ref_pkg::*;
(
  // Clock
  input  logic  clock,
  // Command side
  input  logic  cmd_ready,
  input  logic  resp_valid,
  input  resp_t resp,
  output logic  cmd_valid,
  output cmd_t  cmd
);
  resp_t r;
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end
  // Hold the command until taken, then scramble it and wait for the answer
  task automatic send(op_t o, func_t f, psel_t p, logic on, logic signed [47:0] v);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd       <= '{o, f, p, on, v};
    @(negedge clock);
    while (!cmd_ready) @(negedge clock);
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd       <= ~cmd;
    @(negedge clock);
    while (!resp_valid) @(negedge clock);
    r = resp;
  endtask : send
endmodule : ref_host

// [relative_reference_offset_asserts.sv]
// Port checks of the relative reference unit
`timescale 1ns/1ns
`include "ref_map.svh"
module reference_checker
  import ref_pkg::*;
(
  // Clock and reset
  input logic       clock,
  input logic       resetn,
  // Command side
  input logic       cmd_valid,
  input logic       cmd_ready,
  input cmd_t       cmd,
  input logic       resp_valid,
  input resp_t      resp,
  // Measurement side
  input func_t      active_function,
  input logic       reading_valid,
  input reading_t   reading,
  input logic       result_valid,
  input reading_t   result,
  // Status
  input logic [8:0] relative_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire take = cmd_valid && cmd_ready;
  sequence s_busy;
    !cmd_ready [*2] ##1 cmd_ready;
  endsequence
  sequence s_answer;
    !resp_valid ##1 resp_valid ##1 !resp_valid;
  endsequence
  AST_BUSY: assert property (take |=> s_busy) else $error("busy window wrong");
  AST_ANSWER: assert property (take |=> s_answer) else $error("answer out of time");
  AST_DEFAULT: assert property (
    take && cmd.op == OP_QUERY_REF && cmd.psel == PSEL_DEFAULT |-> ##2 resp.data == 0)
    else $error("default not zero");
  AST_MAX: assert property (
    take && cmd.op == OP_QUERY_REF && cmd.psel == PSEL_MAX && cmd.func == dc_voltage_function
    |-> ##2 resp.data == `LIM_DC_VOLT_HI) else $error("wrong maximum");
  AST_RANGE: assert property (
    take && cmd.op == OP_SET_REF && cmd.psel == PSEL_VALUE && cmd.func == dc_voltage_function
    && cmd.value > `LIM_DC_VOLT_HI |-> ##2 resp.param_error) else $error("range not refused");
  AST_ACQ_OTHER: assert property (
    (take && cmd.op == OP_ACQUIRE && cmd.func < `FUNC_COUNT)
    ##1 ($past(cmd.func) != active_function) |=> resp.acquire_error)
    else $error("acquire not refused");
  AST_FLAG: assert property (
    take && cmd.op == OP_SET_STATE && cmd.psel == PSEL_VALUE && cmd.func < 9
    |-> ##2 relative_mode[$past(cmd.func, 2)] == $past(cmd.on, 2)) else $error("flag wrong");
  AST_PASS: assert property (
    reading_valid && !relative_mode[active_function]
    |=> result_valid && result.value == $past(reading.value)) else $error("reading altered");
endmodule : reference_checker

bind relative_reference_offset reference_checker i_chk (
  .clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .resp_valid(resp_valid), .resp(resp), .active_function(active_function),
  .reading_valid(reading_valid), .reading(reading), .result_valid(result_valid),
  .result(result), .relative_mode(relative_mode));

// [tb_relative_reference_offset.sv]
// Testbench of the relative reference unit
`timescale 1ns/1ns
`include "ref_map.svh"
module tb_relative_reference_offset
  import ref_pkg::*;
;
  logic       clock;
  logic       resetn = 1'b0;
  logic       cmd_valid;
  logic       cmd_ready;
  cmd_t       cmd;
  logic       resp_valid;
  resp_t      resp;
  func_t      active_function = dc_voltage_function;
  logic       reading_valid = 1'b0;
  reading_t   reading = '0;
  logic       result_valid;
  reading_t   result;
  logic [8:0] relative_mode;
  int         n_mismatch = 0;
  int         n_compared = 0;
  int         cycles = 0;
  relative_reference_offset i_dut (
    .clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .resp_valid(resp_valid), .resp(resp), .active_function(active_function),
    .reading_valid(reading_valid), .reading(reading), .result_valid(result_valid),
    .result(result), .relative_mode(relative_mode));
  ref_host i_host (.clock(clock), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
    .resp(resp), .cmd_valid(cmd_valid), .cmd(cmd));
  function automatic logic signed [47:0] q(int n);
    return n * 65536;
  endfunction : q
  task automatic chk_v(logic signed [47:0] got, logic signed [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_b(logic got, logic exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_b
  // Command with expected data and flags {acquired, param error, acquire error}
  task automatic ex(op_t o, func_t f, psel_t p, logic signed [47:0] v, e, logic [2:0] fl);
    i_host.send(o, f, p, v[0], v);
    chk_b(i_host.r.param_error, fl[1]);
    chk_b(i_host.r.acquire_error, fl[0]);
    if (o == OP_QUERY_STATE)
      chk_b(i_host.r.data[0], e[0]);
    else if (o != OP_SET_STATE && !fl[0])
      chk_v(i_host.r.data, e);
    if (p == PSEL_VALUE && o inside {OP_SET_REF, OP_ACQUIRE, OP_QUERY_REF} && fl[1:0] == 0)
      chk_b(i_host.r.src_acquired, fl[2]);
  endtask : ex
  // Reading in, result checked in the following cycle
  task automatic rd(int v, logic ovf, logic signed [47:0] e);
    @(posedge clock);
    reading_valid <= 1'b1;
    reading       <= '{q(v), ovf};
    @(posedge clock);
    reading_valid <= 1'b0;
    reading       <= ~reading;
    @(negedge clock);
    chk_b(result_valid, 1'b1);
    chk_b(result.overflow, ovf);
    chk_v(result.value, e);
  endtask : rd
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk_v(relative_mode, 0);
    ex(OP_QUERY_REF, ac_voltage_function, PSEL_VALUE, 0, 0, 0);
    ex(OP_QUERY_REF, dc_voltage_function, PSEL_DEFAULT, 0, 0, 0);
    ex(OP_QUERY_REF, ac_voltage_function, PSEL_MIN, 0, -`LIM_AC_VOLT_HI, 0);
    ex(OP_QUERY_REF, dc_voltage_function, PSEL_MAX, 0, `LIM_DC_VOLT_HI, 0);
    ex(OP_QUERY_REF, res2_function, PSEL_MIN, 0, 0, 0);
    ex(OP_QUERY_REF, temperature_function, PSEL_MIN, 0, -`LIM_TMP_MAG, 0);
    ex(OP_QUERY_REF, period_function, PSEL_MAX, 0, `LIM_PERIOD_HI, 0);
    ex(OP_SET_REF, temperature_function, PSEL_MAX, 0, `LIM_TMP_HI, 0);
    $display("test limits done");
    ex(OP_SET_REF, dc_voltage_function, PSEL_VALUE, `LIM_DC_VOLT_HI + 1, 0, 3'b010);
    ex(OP_QUERY_REF, dc_voltage_function, PSEL_VALUE, 0, 0, 0);
    ex(OP_SET_REF, dc_voltage_function, PSEL_VALUE, `LIM_DC_VOLT_HI, `LIM_DC_VOLT_HI, 0);
    ex(OP_SET_REF, res4_function, PSEL_VALUE, -1, 0, 3'b010);
    ex(OP_SET_REF, frequency_function, PSEL_VALUE, `LIM_FRQ_HI + 1, 0, 3'b010);
    ex(OP_SET_REF, ac_current_function, PSEL_VALUE, `LIM_CUR_HI + 1, 0, 3'b010);
    ex(OP_SET_REF, dc_current_function, PSEL_MIN, 0, -`LIM_CUR_HI, 0);
    ex(OP_QUERY_REF, ac_voltage_function, PSEL_VALUE, 0, 0, 0);
    ex(OP_QUERY_REF, func_t'(4'h9), PSEL_VALUE, 0, 0, 3'b010);
    ex(op_t'(3'h5), dc_voltage_function, PSEL_VALUE, 0, 0, 3'b010);
    $display("test programming done");
    ex(OP_SET_STATE, dc_voltage_function, PSEL_VALUE, 1, 0, 0);
    ex(OP_QUERY_STATE, dc_voltage_function, PSEL_VALUE, 0, 1, 0);
    chk_v(relative_mode, 9'h008);
    rd(2000, 1'b0, q(2000) - `LIM_DC_VOLT_HI);
    ex(OP_SET_STATE, dc_voltage_function, PSEL_VALUE, 0, 0, 0);
    rd(5, 1'b0, q(5));
    ex(OP_ACQUIRE, dc_voltage_function, PSEL_VALUE, 0, q(5), 3'b100);
    ex(OP_QUERY_REF, dc_voltage_function, PSEL_VALUE, 0, q(5), 3'b100);
    ex(OP_SET_STATE, dc_voltage_function, PSEL_VALUE, 1, 0, 0);
    rd(8, 1'b0, q(3));
    ex(OP_SET_REF, dc_voltage_function, PSEL_VALUE, q(7), q(7), 0);
    ex(OP_QUERY_REF, dc_voltage_function, PSEL_VALUE, 0, q(7), 0);
    $display("test offset done");
    ex(OP_ACQUIRE, ac_voltage_function, PSEL_VALUE, 0, 0, 3'b001);
    rd(1, 1'b1, q(1) - q(7));
    ex(OP_ACQUIRE, dc_voltage_function, PSEL_VALUE, 0, 0, 3'b001);
    ex(OP_QUERY_REF, dc_voltage_function, PSEL_VALUE, 0, q(7), 0);
    @(posedge clock);
    active_function <= ac_voltage_function;
    ex(OP_ACQUIRE, ac_voltage_function, PSEL_VALUE, 0, 0, 3'b001);
    ex(OP_QUERY_REF, ac_voltage_function, PSEL_VALUE, 0, 0, 0);
    $display("test acquire errors done");
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk_v(relative_mode, 0);
    ex(OP_QUERY_REF, dc_voltage_function, PSEL_VALUE, 0, 0, 0);
    $display("test reset done");
    give_verdict();
  end
endmodule : tb_relative_reference_offset
